// File: verilog/fpe_pkg.sv
// Package for the flash program and erase command block.
// Assumes a 10 MHz system clock and a plain register port with 32-bit data.
package fpe_pkg;

	localparam logic [3:0]  ADDR_TARGET      = 4'h0;
	localparam logic [3:0]  ADDR_WORD        = 4'h4;
	localparam logic [3:0]  ADDR_COMMAND     = 4'h8;

	localparam logic [15:0] CMD_KEY          = 16'ha442;
	localparam int          KEY_LSB          = 16;
	localparam int          BIT_PROGRAM      = 0;
	localparam int          BIT_ERASE        = 1;
	localparam int          OFFSET_W         = 14;
	localparam logic [31:0] RESET_ZERO       = 32'h0000_0000;

	localparam int          CLK_HZ           = 10_000_000;
	localparam int          PROGRAM_TIME_US  = 50;
	localparam int          ERASE_TIME_MS    = 25;
	localparam int          PROGRAM_CYCLES   = PROGRAM_TIME_US * (CLK_HZ / 1_000_000);
	localparam int          ERASE_CYCLES     = ERASE_TIME_MS * (CLK_HZ / 1_000);

	typedef enum logic [1:0]
	{
		FPE_IDLE    = 2'b00,
		FPE_PROGRAM = 2'b01,
		FPE_ERASE   = 2'b10
	} fpe_state_t;

	typedef struct packed
	{
		logic        go;
		logic        erase;
		logic [13:0] offset;
		logic [31:0] data;
	} fpe_array_cmd_t;

endpackage : fpe_pkg

// File: verilog/fpe_flash_ctrl.sv
// Flash program and erase command register with offset and data registers.
// Assumes the array accepts one command pulse and the timers here model its run time.
//
// Behaviour
// - Page erase bit erases the page at the current target offset.
// - Page erase bit reads one while its erase runs, zero after.
// - Page erase finishes within 25 ms.
// - Program bit writes the data word at the target offset.
// - Program bit reads one while programming runs, zero after.
// - Word program finishes within 50 us.
// - Writing zero to a command bit changes nothing and aborts nothing.
// - A keyed command write made while idle with a command bit set launches the cycle at the target offset.
// - Target offset register supplies a 14-bit flash offset.
// - Data register holds the program word and is unused by erase.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module fpe_flash_ctrl
	import fpe_pkg::*;
#(
	parameter int ERASE_COUNT   = ERASE_CYCLES,
	parameter int PROGRAM_COUNT = PROGRAM_CYCLES
)
(
	// Clock and reset.
	input  wire logic           clk,
	input  wire logic           rst,
	// Register port.
	input  wire logic [3:0]     reg_addr,
	input  wire logic [31:0]    reg_wdata,
	input  wire logic           reg_write,
	input  wire logic           reg_read,
	output logic      [31:0]    reg_rdata,
	// Flash array command.
	output fpe_array_cmd_t      array_cmd,
	output logic                array_busy
);

	// Counts above the bounds would let a run outlast its time limit.
	if (ERASE_COUNT < 1 || PROGRAM_COUNT < 1 || ERASE_COUNT > ERASE_CYCLES
		|| PROGRAM_COUNT > PROGRAM_CYCLES)
	begin : g_bad_counts
		$error("fpe_flash_ctrl: timing counts out of range");
	end

	localparam int PROG_BOUND = PROGRAM_CYCLES;

	logic [13:0]     flash_target_offset_q;
	logic [31:0]     flash_program_word_q;
	fpe_state_t      state_q;
	fpe_state_t      state_d;
	logic [31:0]     timer_q;
	logic [31:0]     timer_d;
	logic [31:0]     rdata_q;
	logic [31:0]     busy_len_q;
	fpe_array_cmd_t  cmd_q;

	wire wr_target  = reg_write && (reg_addr == ADDR_TARGET);
	wire wr_word    = reg_write && (reg_addr == ADDR_WORD);
	wire wr_command = reg_write && (reg_addr == ADDR_COMMAND);
	wire key_ok     = reg_wdata[31:KEY_LSB] == CMD_KEY;
	wire idle       = state_q == FPE_IDLE;
	// A write of zero starts nothing, so a running operation is left alone.
	// Writes during a running operation are dropped to keep the array stable.
	wire start_prog  = wr_command && key_ok && idle && reg_wdata[BIT_PROGRAM];
	// Program wins when both bits are set; software must not do that.
	wire start_erase = wr_command && key_ok && idle && reg_wdata[BIT_ERASE]
		&& !reg_wdata[BIT_PROGRAM];
	wire timer_done  = timer_q == 32'h0000_0001;

	wire prog_busy  = state_q == FPE_PROGRAM;
	wire erase_busy = state_q == FPE_ERASE;

	wire [31:0] cmd_view = {16'h0000, 14'h0000, erase_busy, prog_busy};
	wire [31:0] read_mux =
		(reg_addr == ADDR_TARGET)  ? {18'h00000, flash_target_offset_q} :
		(reg_addr == ADDR_WORD)    ? flash_program_word_q :
		(reg_addr == ADDR_COMMAND) ? cmd_view : RESET_ZERO;

	always_comb
	begin
		state_d = state_q;
		timer_d = timer_q;
		case (state_q)
			FPE_IDLE:
			begin
				if (start_prog)
				begin
					state_d = FPE_PROGRAM;
					timer_d = 32'(PROGRAM_COUNT);
				end
				else if (start_erase)
				begin
					state_d = FPE_ERASE;
					timer_d = 32'(ERASE_COUNT);
				end
			end
			FPE_PROGRAM, FPE_ERASE:
			begin
				timer_d = timer_q - 32'h0000_0001;
				if (timer_done)
					state_d = FPE_IDLE;
			end
			default:
			begin
				state_d = FPE_IDLE;
				timer_d = RESET_ZERO;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= FPE_IDLE;
			timer_q <= RESET_ZERO;
		end
		else
		begin
			state_q <= state_d;
			timer_q <= timer_d;
		end
	end

	// The offset and data are locked while an operation runs so the array sees stable inputs.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flash_target_offset_q <= 14'h0000;
			flash_program_word_q  <= RESET_ZERO;
		end
		else
		begin
			if (wr_target && idle)
				flash_target_offset_q <= reg_wdata[OFFSET_W-1:0];
			if (wr_word && idle)
				flash_program_word_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_q   <= '0;
			rdata_q <= RESET_ZERO;
		end
		else
		begin
			cmd_q.go     <= start_prog || start_erase;
			cmd_q.erase  <= start_erase;
			cmd_q.offset <= flash_target_offset_q;
			cmd_q.data   <= start_erase ? RESET_ZERO : flash_program_word_q;
			rdata_q      <= reg_read ? read_mux : RESET_ZERO;
		end
	end

	assign reg_rdata  = rdata_q;
	assign array_cmd  = cmd_q;
	assign array_busy = !idle;

	// An independent run-length count lets the time bounds be checked without trusting the timer.
	wire [31:0] busy_len_d = array_busy ? busy_len_q + 32'h0000_0001 : RESET_ZERO;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busy_len_q <= RESET_ZERO;
		else
			busy_len_q <= busy_len_d;
	end

	erase_bound_a: assert property (@(posedge clk) disable iff (rst)
		erase_busy |-> busy_len_q < 32'(ERASE_CYCLES))
		else $error("page erase ran too long");

	prog_bound_a: assert property (@(posedge clk) disable iff (rst)
		$rose(prog_busy) |-> ##[1:PROG_BOUND] !prog_busy)
		else $error("word program ran too long");

	erase_start_a: assert property (@(posedge clk) disable iff (rst)
		start_erase |=> erase_busy && cmd_q.go && cmd_q.erase)
		else $error("erase did not start");

	prog_start_a: assert property (@(posedge clk) disable iff (rst)
		start_prog |=> prog_busy && cmd_q.go && !cmd_q.erase
			&& cmd_q.data == $past(flash_program_word_q))
		else $error("program did not start with data");

	no_key_a: assert property (@(posedge clk) disable iff (rst)
		(wr_command && !key_ok && idle) |=> idle)
		else $error("unkeyed command started");

	zero_write_a: assert property (@(posedge clk) disable iff (rst)
		(wr_command && !idle && !timer_done) |=> !idle)
		else $error("write aborted operation");

	busy_read_a: assert property (@(posedge clk) disable iff (rst)
		(reg_read && reg_addr == ADDR_COMMAND) |=> reg_rdata[BIT_ERASE] == $past(erase_busy)
			&& reg_rdata[31:KEY_LSB] == 16'h0000)
		else $error("command readback wrong");

	prog_read_a: assert property (@(posedge clk) disable iff (rst)
		(reg_read && reg_addr == ADDR_COMMAND) |=> reg_rdata[BIT_PROGRAM] == $past(prog_busy))
		else $error("program busy readback wrong");

	offset_cmd_a: assert property (@(posedge clk) disable iff (rst)
		(start_prog || start_erase) |=> cmd_q.offset == $past(flash_target_offset_q))
		else $error("command offset wrong");

	erase_data_a: assert property (@(posedge clk) disable iff (rst)
		start_erase |=> cmd_q.data == RESET_ZERO)
		else $error("erase used data word");

	launch_a: assert property (@(posedge clk) disable iff (rst)
		(wr_command && key_ok && idle && (reg_wdata[1:0] != 2'b00)) |=> !idle)
		else $error("keyed command did not launch");

	// Run lengths are judged on the separate count, so a stuck timer cannot hide.
	prog_len_a: assert property (@(posedge clk) disable iff (rst)
		prog_busy |-> busy_len_q < 32'(PROGRAM_CYCLES))
		else $error("word program exceeded its bound");

	prog_exact_a: assert property (@(posedge clk) disable iff (rst)
		$fell(prog_busy) |-> busy_len_q == 32'(PROGRAM_COUNT))
		else $error("word program length wrong");

	erase_exact_a: assert property (@(posedge clk) disable iff (rst)
		$fell(erase_busy) |-> busy_len_q == 32'(ERASE_COUNT))
		else $error("page erase length wrong");

	run_end_a: assert property (@(posedge clk) disable iff (rst)
		$fell(array_busy) |-> $past(timer_done))
		else $error("operation ended early");

	busy_cmd_a: assert property (@(posedge clk) disable iff (rst)
		(wr_command && !idle && !timer_done) |=> timer_q == $past(timer_q) - 32'h0000_0001)
		else $error("write disturbed running operation");

	go_pulse_a: assert property (@(posedge clk) disable iff (rst)
		cmd_q.go |=> !cmd_q.go)
		else $error("array go longer than one cycle");

	go_busy_a: assert property (@(posedge clk) disable iff (rst)
		$rose(array_busy) |-> cmd_q.go)
		else $error("busy without array go");

	go_idle_a: assert property (@(posedge clk) disable iff (rst)
		!(start_prog || start_erase) |=> !cmd_q.go)
		else $error("array go without command");

	erase_flag_a: assert property (@(posedge clk) disable iff (rst)
		cmd_q.erase |-> cmd_q.go)
		else $error("erase flag without go");

	erase_go_a: assert property (@(posedge clk) disable iff (rst)
		(cmd_q.go && cmd_q.erase) |-> erase_busy)
		else $error("erase go without erase busy");

	prog_go_a: assert property (@(posedge clk) disable iff (rst)
		(cmd_q.go && !cmd_q.erase) |-> prog_busy)
		else $error("program go without program busy");

	prog_data_a: assert property (@(posedge clk) disable iff (rst)
		(cmd_q.go && !cmd_q.erase) |-> cmd_q.data == flash_program_word_q)
		else $error("program go with wrong word");

	erase_clear_a: assert property (@(posedge clk) disable iff (rst)
		(erase_busy && timer_done) |=> !erase_busy)
		else $error("erase busy did not clear");

	prog_clear_a: assert property (@(posedge clk) disable iff (rst)
		(prog_busy && timer_done) |=> !prog_busy)
		else $error("program busy did not clear");

	cmd_rsvd_a: assert property (@(posedge clk) disable iff (rst)
		(reg_read && reg_addr == ADDR_COMMAND) |=> reg_rdata[15:2] == 14'h0000)
		else $error("command spare bits not zero");

	offset_hold_a: assert property (@(posedge clk) disable iff (rst)
		!idle |=> $stable(flash_target_offset_q))
		else $error("offset changed while busy");

	word_hold_a: assert property (@(posedge clk) disable iff (rst)
		!idle |=> $stable(flash_program_word_q))
		else $error("program word changed while busy");

	offset_load_a: assert property (@(posedge clk) disable iff (rst)
		(wr_target && idle) |=> flash_target_offset_q == $past(reg_wdata[OFFSET_W-1:0]))
		else $error("offset write lost");

	word_load_a: assert property (@(posedge clk) disable iff (rst)
		(wr_word && idle) |=> flash_program_word_q == $past(reg_wdata))
		else $error("program word write lost");

	target_read_a: assert property (@(posedge clk) disable iff (rst)
		(reg_read && reg_addr == ADDR_TARGET) |=> reg_rdata == {18'h00000, $past(flash_target_offset_q)})
		else $error("offset readback wrong");

	word_read_a: assert property (@(posedge clk) disable iff (rst)
		(reg_read && reg_addr == ADDR_WORD) |=> reg_rdata == $past(flash_program_word_q))
		else $error("program word readback wrong");

endmodule : fpe_flash_ctrl

// File: test/test_fpe_flash_ctrl.sv
// Testbench for the flash program and erase command block.
// Assumes shortened run times; the register port is driven directly.
`timescale 1ns/1ps
module test_fpe_flash_ctrl;
	import fpe_pkg::*;
	localparam int ER = 20;
	localparam int PR = 8;
	logic           clk = 0;
	logic           rst = 1;
	logic [3:0]     reg_addr = 4'h0;
	logic [31:0]    reg_wdata = 32'h0;
	logic           reg_write = 0;
	logic           reg_read = 0;
	logic [31:0]    reg_rdata;
	fpe_array_cmd_t array_cmd;
	logic           array_busy;
	int             mismatches = 0;
	int             total_checks = 0;
	int             cyc = 0;
	int             t0;
	logic [31:0]    rd_v;
	fpe_flash_ctrl #(.ERASE_COUNT(ER), .PROGRAM_COUNT(PR)) DUT (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .array_cmd(array_cmd),
		.array_busy(array_busy));
	always #50 clk = ~clk;
	// A hung wait must still reach the verdict, so the cycle count is capped.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			mismatches++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1;
		@(posedge clk);
		reg_write <= 0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge clk);
		reg_read <= 0;
		#1;
		rd_v = reg_rdata;
	endtask : rd
	task automatic wait_idle(input int lim);
		for (int i = 0; i < 200 && array_busy !== 1'b0; i++)
			@(posedge clk) #1;
		chk("run time", 48'(cyc - t0), 48'(lim));
	endtask : wait_idle
	task automatic t_prog;
		wr(ADDR_TARGET, 32'hffff_ffff);
		wr(ADDR_WORD, 32'h1234_5678);
		rd(ADDR_TARGET);
		chk("offset read", 48'(rd_v), 48'h3fff);
		rd(ADDR_WORD);
		chk("word read", 48'(rd_v), 48'h1234_5678);
		wr(ADDR_COMMAND, {CMD_KEY, 16'h0001});
		t0 = cyc;
		chk("program cmd", array_cmd, {1'b1, 1'b0, 14'h3fff, 32'h1234_5678});
		rd(ADDR_COMMAND);
		chk("program busy bit", 48'(rd_v), 48'h1);
		wr(ADDR_COMMAND, {CMD_KEY, 16'h0000});
		chk("busy after zero", 48'(array_busy), 48'h1);
		wait_idle(PR);
		rd(ADDR_COMMAND);
		chk("program done bit", 48'(rd_v), 48'h0);
	endtask : t_prog
	task automatic t_erase;
		wr(ADDR_TARGET, 32'h0000_0123);
		wr(ADDR_COMMAND, {CMD_KEY, 16'h0002});
		t0 = cyc;
		chk("erase cmd", array_cmd, {1'b1, 1'b1, 14'h0123, 32'h0});
		rd(ADDR_COMMAND);
		chk("erase busy bit", 48'(rd_v), 48'h2);
		wait_idle(ER);
		rd(ADDR_COMMAND);
		chk("erase done bit", 48'(rd_v), 48'h0);
	endtask : t_erase
	task automatic t_nokey;
		wr(ADDR_COMMAND, 32'h0000_0001);
		chk("unkeyed go", 48'(array_cmd.go), 48'h0);
		chk("unkeyed busy", 48'(array_busy), 48'h0);
		rd(4'hc);
		chk("unmapped read", 48'(rd_v), 48'h0);
	endtask : t_nokey
	task automatic close_out;
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 0;
		t_nokey();
		t_prog();
		t_erase();
		close_out();
	end
endmodule : test_fpe_flash_ctrl
